// ==== src/bridge_reset_clock_control.sv ====
// Contract
// - Upstream reset tri-states every PCI interface at once
// - Upstream reset returns all registers to defaults
// - Upstream reset edges may be fully asynchronous
// - No access until 2^25 clocks after release
// - Both downstream resets follow upstream reset
// - Software bit holds downstream reset until cleared
// - Asserted downstream reset tri-states that port's control and grant lines
// - Downstream reset edges may be asynchronous
// - Drive address, byte enables, parity low; code drives them only while downstream reset is on and upstream reset is off
// - Downstream reset flushes posted and delayed buffers
// - Software-only downstream reset keeps bridge accessible
// - Downstream logic clocked from upstream-derived clock
// - Sixteen downstream clock outputs from upstream clock
// - Configuration accepted only from upstream bus
// - Ignore interrupt acknowledge and special cycles
// - Claim I/O read only inside window
`timescale 1ns/10ps
`default_nettype none

module bridge_reset_clock_control (
  // Clock and upstream reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Software control and configuration decode
  input wire logic down1_soft_reset,
  input wire logic down2_soft_reset,
  input wire logic upstream_config_req,
  input wire logic down1_config_req,
  input wire logic down2_config_req,
  input wire logic upstream_cmd_valid,
  input wire logic [3:0] upstream_command_byte_enables,
  input wire logic io_addr_in_window,
  // Downstream reset pins, open drain
  input wire logic down1_reset_n_in,
  input wire logic down2_reset_n_in,
  output logic down1_reset_n_out,
  output logic down1_reset_n_oe,
  output logic down2_reset_n_out,
  output logic down2_reset_n_oe,
  // Upstream interface drive control
  output logic upstream_drive_en,
  output logic upstream_accessible,
  output logic config_accept,
  output logic io_claim,
  output logic io_forward,
  // Downstream port 1
  output logic [bridge_reset_pkg::AD_W-1:0] down1_address_data,
  output logic [bridge_reset_pkg::CBE_W-1:0] down1_command_byte_enables,
  output logic down1_parity,
  output logic down1_bus_oe,
  output logic down1_ctrl_oe,
  output logic [bridge_reset_pkg::DOWN_GNT_W-1:0] down1_grant_oe,
  // Downstream port 2
  output logic [bridge_reset_pkg::AD_W-1:0] down2_address_data,
  output logic [bridge_reset_pkg::CBE_W-1:0] down2_command_byte_enables,
  output logic down2_parity,
  output logic down2_bus_oe,
  output logic down2_ctrl_oe,
  output logic [bridge_reset_pkg::DOWN_GNT_W-1:0] down2_grant_oe,
  // Buffer flush and downstream clocks
  output logic [bridge_reset_pkg::BUF_FLUSH_N-1:0] buffer_flush,
  output logic down_clk_en,
  output logic [bridge_reset_pkg::CLKOUT_N-1:0] downstream_clock_outputs
);

  parameter int unsigned HOLD_CYCLES = bridge_reset_pkg::POST_RESET_INACCESSIBLE_TIME;

  //////////////////////////////////////////////////////////////////////////////
  // Reset release synchroniser: assert at once, release after two edges
  logic [1:0] rst_sync_q;
  logic rst_int_n;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // Downstream reset pin synchronisers; pins are open drain and may be
  // pulled low by another agent, so we watch the wire, not our drive
  logic [1:0] d1_pin_sync_q;
  logic [1:0] d2_pin_sync_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      d1_pin_sync_q <= 2'h0;
      d2_pin_sync_q <= 2'h0;
    end else begin
      d1_pin_sync_q <= {d1_pin_sync_q[0], down1_reset_n_in};
      d2_pin_sync_q <= {d2_pin_sync_q[0], down2_reset_n_in};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Post-release inaccessibility counter
  bridge_reset_pkg::access_state_e acc_q, acc_d;
  logic [bridge_reset_pkg::HOLD_CNT_W-1:0] hold_cnt_q, hold_cnt_d;

  always_comb begin
    acc_d = acc_q;
    hold_cnt_d = hold_cnt_q;
    case (acc_q)
      bridge_reset_pkg::ACC_RESET: begin
        acc_d = bridge_reset_pkg::ACC_WAIT;
        hold_cnt_d = '0;
      end
      bridge_reset_pkg::ACC_WAIT: begin
        hold_cnt_d = hold_cnt_q + 1'b1;
        if (hold_cnt_q == HOLD_CYCLES[bridge_reset_pkg::HOLD_CNT_W-1:0] - 1'b1) begin
          acc_d = bridge_reset_pkg::ACC_OPEN;
        end
      end
      default: begin
        acc_d = bridge_reset_pkg::ACC_OPEN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      acc_q <= bridge_reset_pkg::ACC_RESET;
      hold_cnt_q <= '0;
    end else begin
      acc_q <= acc_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Downstream reset requests and command decode, registered
  logic d1_rst_q, d1_rst_d;
  logic d2_rst_q, d2_rst_d;
  logic open_d;
  logic cfg_d, claim_d;
  logic cfg_q, claim_q;
  logic div_tick;
  logic [3:0] div_q, div_d;
  logic clk_en_q;
  logic open_q;

  always_comb begin
    // Software bit only; the wire is sensed separately, so our own drive
    // read back through the pin cannot hold the request on by itself
    d1_rst_d = down1_soft_reset;
    d2_rst_d = down2_soft_reset;
    // Soft downstream reset leaves the upstream side open
    open_d = (acc_q == bridge_reset_pkg::ACC_OPEN);
    // Downstream configuration requests are never honoured
    cfg_d = open_d && upstream_config_req;
    claim_d = 1'b0;
    if (open_d && upstream_cmd_valid) begin
      if (upstream_command_byte_enables == bridge_reset_pkg::CMD_INT_ACK) begin
        claim_d = 1'b0;
      end else if (upstream_command_byte_enables == bridge_reset_pkg::CMD_SPECIAL) begin
        claim_d = 1'b0;
      end else if (upstream_command_byte_enables == bridge_reset_pkg::CMD_IO_READ) begin
        claim_d = io_addr_in_window;
      end
    end
    div_tick = (div_q == bridge_reset_pkg::CLK_DIV_LAST);
    // Reload on the tick; with the last count at zero the enable fires every cycle
    div_d = div_tick ? bridge_reset_pkg::CLK_DIV_LAST : div_q - 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      d1_rst_q <= 1'b1;
      d2_rst_q <= 1'b1;
      cfg_q <= 1'b0;
      claim_q <= 1'b0;
      open_q <= 1'b0;
      div_q <= bridge_reset_pkg::CLK_DIV_LAST;
      clk_en_q <= 1'b0;
    end else begin
      d1_rst_q <= d1_rst_d;
      d2_rst_q <= d2_rst_d;
      cfg_q <= cfg_d;
      claim_q <= claim_d;
      open_q <= open_d;
      div_q <= div_d;
      clk_en_q <= div_tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs: reset flops take the upstream reset directly so tri-state
  // acts at once, without waiting for the release synchroniser
  logic d1_hold_q, d1_hold_d;
  logic d2_hold_q, d2_hold_d;
  logic d1_bus_q, d1_bus_d;
  logic d2_bus_q, d2_bus_d;
  logic [bridge_reset_pkg::BUF_FLUSH_N-1:0] flush_q, flush_d;
  logic up_drv_q, up_drv_d;
  logic d1_line, d2_line;

  // Our drive follows only upstream reset and the software bit, never the
  // wire, so the open-drain readback cannot latch the reset on forever
  always_comb begin
    d1_hold_d = !rst_int_n || d1_rst_q;
    d2_hold_d = !rst_int_n || d2_rst_q;
    // Line asserted by anyone, our own readback included
    d1_line = d1_rst_q || !d1_pin_sync_q[1];
    d2_line = d2_rst_q || !d2_pin_sync_q[1];
    d1_bus_d = rst_int_n && d1_line;
    d2_bus_d = rst_int_n && d2_line;
    flush_d = {!rst_int_n || d2_line, !rst_int_n || d1_line};
    up_drv_d = rst_int_n;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      d1_hold_q <= 1'b1;
      d2_hold_q <= 1'b1;
      d1_bus_q <= 1'b0;
      d2_bus_q <= 1'b0;
      flush_q <= '1;
      up_drv_q <= 1'b0;
    end else begin
      d1_hold_q <= d1_hold_d;
      d2_hold_q <= d2_hold_d;
      d1_bus_q <= d1_bus_d;
      d2_bus_q <= d2_bus_d;
      flush_q <= flush_d;
      up_drv_q <= up_drv_d;
    end
  end

  // Resets drive the wire low; downstream data held low, control released
  assign down1_reset_n_out = 1'b0;
  assign down2_reset_n_out = 1'b0;
  assign down1_reset_n_oe = d1_hold_q;
  assign down2_reset_n_oe = d2_hold_q;
  assign upstream_drive_en = up_drv_q;
  assign upstream_accessible = open_q;
  assign config_accept = cfg_q;
  assign io_claim = claim_q;
  assign io_forward = claim_q;
  assign down1_address_data = '0;
  assign down1_command_byte_enables = '0;
  assign down1_parity = 1'b0;
  assign down2_address_data = '0;
  assign down2_command_byte_enables = '0;
  assign down2_parity = 1'b0;
  // Data lines are driven low only while the port is in reset and upstream reset is released; idle otherwise
  assign down1_bus_oe = d1_bus_q;
  assign down2_bus_oe = d2_bus_q;
  assign down1_ctrl_oe = 1'b0;
  assign down2_ctrl_oe = 1'b0;
  assign down1_grant_oe = '0;
  assign down2_grant_oe = '0;
  assign buffer_flush = flush_q;
  assign down_clk_en = clk_en_q;
  // Clock outputs follow the enable pulse; no PLL in this block
  assign downstream_clock_outputs = {bridge_reset_pkg::CLKOUT_N{clk_en_q}};

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [bridge_reset_pkg::HOLD_CNT_W-1:0] chk_cnt_q;
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      chk_cnt_q <= '0;
    end else if (!open_q) begin
      chk_cnt_q <= chk_cnt_q + 1'b1;
    end
  end

  a_early_access: assert property (@(posedge ref_clk) disable iff (!arst_n)
    open_q |-> chk_cnt_q >= HOLD_CYCLES[bridge_reset_pkg::HOLD_CNT_W-1:0])
    else $error("bridge opened before hold time");
  a_down_rst_follow: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !rst_int_n |=> down1_reset_n_oe && down2_reset_n_oe)
    else $error("downstream reset not held during upstream reset");
  a_soft_reset_hold: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    down1_soft_reset ##1 down1_soft_reset |=> down1_reset_n_oe)
    else $error("soft reset not driven on port 1");
  a_no_self_latch: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    !down1_soft_reset ##1 !down1_soft_reset |=> !down1_reset_n_oe)
    else $error("port 1 reset drive stuck after soft bit cleared");
  a_pin_reset_flush: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    !d2_pin_sync_q[1] |=> buffer_flush[1])
    else $error("port 2 buffers not flushed");
  a_data_low: assert property (@(posedge ref_clk) disable iff (!arst_n)
    down1_reset_n_oe && upstream_drive_en |-> down1_bus_oe && down1_address_data == '0)
    else $error("port 1 data not driven low in reset");
  a_soft_open: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    upstream_accessible && upstream_config_req && (down1_soft_reset || down2_soft_reset)
    |=> upstream_accessible && config_accept)
    else $error("bridge closed by soft reset");
  a_no_special: assert property (@(posedge ref_clk) disable iff (!arst_n)
    upstream_cmd_valid && upstream_command_byte_enables[3:1] == 3'h0 |=> !io_claim)
    else $error("special or ack command claimed");
  a_io_window: assert property (@(posedge ref_clk) disable iff (!rst_int_n)
    open_d && upstream_cmd_valid && upstream_command_byte_enables == bridge_reset_pkg::CMD_IO_READ
    |=> io_claim == $past(io_addr_in_window))
    else $error("I/O claim mismatches window");
  a_no_down_cfg: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !upstream_config_req |=> !config_accept)
    else $error("configuration accepted without upstream request");
  a_down_cfg_refused: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (down1_config_req || down2_config_req) && !upstream_config_req |=> !config_accept)
    else $error("downstream configuration accepted");

  c_soft_reset: cover property (@(posedge ref_clk) disable iff (!rst_int_n)
    open_q && down1_soft_reset ##2 down1_reset_n_oe);
  c_opened: cover property (@(posedge ref_clk) disable iff (!rst_int_n) $rose(open_q));
  c_io_claim: cover property (@(posedge ref_clk) disable iff (!rst_int_n) io_claim);
  // Foreign agent holds port 2 in reset while we do not drive it
  c_pin_reset: cover property (@(posedge ref_clk) disable iff (!rst_int_n)
    !d2_pin_sync_q[1] && !down2_reset_n_oe ##1 buffer_flush[1]);

endmodule : bridge_reset_clock_control

`default_nettype wire

// ==== common/bridge_reset_pkg.sv ====
package bridge_reset_pkg;

  // Inaccessible window after upstream reset release, in upstream clocks
  localparam int unsigned POST_RESET_INACCESSIBLE_LOG2 = 25;
  localparam int unsigned POST_RESET_INACCESSIBLE_TIME = 2 ** POST_RESET_INACCESSIBLE_LOG2;
  localparam int unsigned HOLD_CNT_W = POST_RESET_INACCESSIBLE_LOG2 + 1;

  // Bus widths
  localparam int unsigned AD_W = 32;
  localparam int unsigned CBE_W = 4;
  localparam int unsigned CLKOUT_N = 16;
  localparam int unsigned DOWN_GNT_W = 8;
  localparam int unsigned BUF_FLUSH_N = 2;

  // Upstream command encodings
  localparam logic [3:0] CMD_INT_ACK = 4'h0;
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_IO_READ = 4'h2;

  // Downstream clock divider: counter reloads CLK_DIV_LAST on each tick, so the clock enable fires every cycle
  localparam logic [3:0] CLK_DIV_LAST = 4'h0;

  typedef enum logic [1:0] {
    ACC_RESET,
    ACC_WAIT,
    ACC_OPEN
  } access_state_e;

endpackage : bridge_reset_pkg

// ==== sim/reset_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// Downstream reset wire: open drain with pull-up, plus an outside agent
module reset_pin_model (
  // Design drive
  input wire logic drv_out,
  input wire logic drv_oe,
  // Outside agent pulling the line low at any moment
  input wire logic ext_assert,
  // Resolved wire level
  output logic pin_n
);
  // Pull-up wins unless some party pulls low; never shows a stale value
  assign pin_n = ((drv_oe && !drv_out) || ext_assert) ? 1'b0 : 1'b1;
endmodule : reset_pin_model

`default_nettype wire

// ==== sim/bridge_reset_clock_control_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module bridge_reset_clock_control_tb_top;
  localparam int unsigned HOLD = 16;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic down1_soft_reset = 1'b0, down2_soft_reset = 1'b0;
  logic upstream_config_req = 1'b0, down1_config_req = 1'b0, down2_config_req = 1'b0;
  logic upstream_cmd_valid = 1'b0, io_addr_in_window = 1'b0;
  logic [3:0] upstream_command_byte_enables = 4'hf;
  logic ext1 = 1'b0, ext2 = 1'b0;
  logic down1_reset_n_in, down2_reset_n_in, down1_reset_n_out, down1_reset_n_oe;
  logic down2_reset_n_out, down2_reset_n_oe, upstream_drive_en, upstream_accessible;
  logic config_accept, io_claim, io_forward, down1_parity, down2_parity;
  logic down1_bus_oe, down1_ctrl_oe, down2_bus_oe, down2_ctrl_oe, down_clk_en;
  logic [bridge_reset_pkg::AD_W-1:0] down1_address_data, down2_address_data;
  logic [bridge_reset_pkg::CBE_W-1:0] down1_command_byte_enables, down2_command_byte_enables;
  logic [bridge_reset_pkg::DOWN_GNT_W-1:0] down1_grant_oe, down2_grant_oe;
  logic [bridge_reset_pkg::BUF_FLUSH_N-1:0] buffer_flush;
  logic [bridge_reset_pkg::CLKOUT_N-1:0] downstream_clock_outputs;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////
  // Design and reset wires
  bridge_reset_clock_control #(.HOLD_CYCLES(HOLD)) u_dut (
    .ref_clk, .arst_n, .down1_soft_reset, .down2_soft_reset, .upstream_config_req,
    .down1_config_req, .down2_config_req, .upstream_cmd_valid,
    .upstream_command_byte_enables, .io_addr_in_window, .down1_reset_n_in,
    .down2_reset_n_in, .down1_reset_n_out, .down1_reset_n_oe, .down2_reset_n_out,
    .down2_reset_n_oe, .upstream_drive_en, .upstream_accessible, .config_accept,
    .io_claim, .io_forward, .down1_address_data, .down1_command_byte_enables,
    .down1_parity, .down1_bus_oe, .down1_ctrl_oe, .down1_grant_oe, .down2_address_data,
    .down2_command_byte_enables, .down2_parity, .down2_bus_oe, .down2_ctrl_oe,
    .down2_grant_oe, .buffer_flush, .down_clk_en, .downstream_clock_outputs);
  reset_pin_model u_pin1 (.drv_out(down1_reset_n_out), .drv_oe(down1_reset_n_oe),
    .ext_assert(ext1), .pin_n(down1_reset_n_in));
  reset_pin_model u_pin2 (.drv_out(down2_reset_n_out), .drv_oe(down2_reset_n_oe),
    .ext_assert(ext2), .pin_n(down2_reset_n_in));

  ////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling so a hang still ends in the report
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic edges(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : edges

  task automatic conclude();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////
  // Upstream reset: everything quiet, then a counted closed window
  task automatic upstream_reset(input int hold_cycles);
    #23 arst_n = 1'b0;
    #1;
    check(upstream_drive_en, 1'b0);
    check({down1_reset_n_oe, down2_reset_n_oe}, 2'b11);
    check({upstream_accessible, down1_bus_oe, down2_bus_oe}, 3'b000);
    edges(hold_cycles);
    check({down1_reset_n_oe, down2_reset_n_oe}, 2'b11);
    arst_n = 1'b1;
    edges(6);
    check({down1_reset_n_oe, down2_reset_n_oe}, 2'b00);
    edges(HOLD + 3 - 6);
    check(upstream_accessible, 1'b0);
    edges(1);
    check(upstream_accessible, 1'b1);
    check(upstream_drive_en, 1'b1);
  endtask : upstream_reset

  // Software reset of one port; bridge stays reachable meanwhile
  task automatic soft_reset(input int port);
    @(posedge ref_clk);
    if (port == 1) down1_soft_reset <= 1'b1;
    else down2_soft_reset <= 1'b1;
    upstream_config_req <= 1'b1;
    edges(3);
    check(port == 1 ? down1_reset_n_oe : down2_reset_n_oe, 1'b1);
    check(buffer_flush, port == 1 ? 2'b01 : 2'b10);
    check({down1_bus_oe, down2_bus_oe}, port == 1 ? 2'b10 : 2'b01);
    check({down1_address_data, down1_command_byte_enables, down1_parity}, 37'h0);
    check({down2_address_data, down2_command_byte_enables, down2_parity}, 37'h0);
    check({down1_grant_oe, down2_grant_oe, down1_ctrl_oe, down2_ctrl_oe}, 18'h0);
    check({upstream_accessible, config_accept}, 2'b11);
    edges(20);
    check(port == 1 ? down1_reset_n_oe : down2_reset_n_oe, 1'b1);
    @(posedge ref_clk);
    down1_soft_reset <= 1'b0;
    down2_soft_reset <= 1'b0;
    upstream_config_req <= 1'b0;
    edges(6);
    check({down1_reset_n_oe, down2_reset_n_oe, buffer_flush}, 4'h0);
  endtask : soft_reset

  // Outside agent pulls port 2 reset low, off the clock edge
  task automatic pin_reset();
    #37 ext2 = 1'b1;
    edges(5);
    check({down2_bus_oe, buffer_flush[1], down2_grant_oe}, 10'h300);
    check(down1_bus_oe, 1'b0);
    #11 ext2 = 1'b0;
    edges(6);
    check({down2_reset_n_oe, down2_bus_oe, buffer_flush}, 4'h0);
  endtask : pin_reset

  // Command decode, configuration source, derived clocks
  task automatic decode();
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      upstream_cmd_valid <= 1'b1;
      upstream_command_byte_enables <= 4'(i / 2);
      io_addr_in_window <= 1'(i % 2);
      edges(2);
      check({io_claim, io_forward}, (i == 5) ? 2'b11 : 2'b00);
    end
    @(posedge ref_clk);
    upstream_cmd_valid <= 1'b0;
    down1_config_req <= 1'b1;
    down2_config_req <= 1'b1;
    edges(2);
    check(config_accept, 1'b0);
    check({down_clk_en, downstream_clock_outputs}, 17'h1ffff);
    down1_config_req <= 1'b0;
    down2_config_req <= 1'b0;
  endtask : decode

  ////////////////////////////////////////////////////////////////
  // Main sequence: start-up reset, scenarios, then a mid-run reset
  initial begin
    repeat (8) @(negedge ref_clk);
    arst_n = 1'b1;
    edges(HOLD + 4);
    check(upstream_accessible, 1'b1);
    soft_reset(1);
    soft_reset(2);
    pin_reset();
    decode();
    upstream_reset(4);
    conclude();
  end
endmodule : bridge_reset_clock_control_tb_top

`default_nettype wire
